// *** bbf_defs.vh ***
// Purpose: Constants for the billboard failover sequencer.
// Assumes: Included by bbf_failover_seq.v and by the test bench.
// Notes: Register offsets are word indexes; byte address is four times the index.
`ifndef BBF_DEFS_VH
`define BBF_DEFS_VH

// ============================================================
// Register indexes
// ============================================================
`define BBF_IDX_CTRL 16'h0004
`define BBF_IDX_TMRA_LO 16'h413C
`define BBF_IDX_TMRA_HI 16'h413D
`define BBF_IDX_TMRB_LO 16'h413E
`define BBF_IDX_TMRB_HI 16'h413F
`define BBF_IDX_STATUS 16'h4140

// ============================================================
// Control fields and reset values
// ============================================================
`define BBF_CTRL_EN_BIT 0
`define BBF_CTRL_SEL_LSB 1
`define BBF_CTRL_SEL_MSB 5
`define BBF_CTRL_RST 8'h14
`define BBF_CTRL_WMASK 8'h3F
`define BBF_SEL_RESERVED 5'h09
`define BBF_SEL_LAST 5'h10
`define BBF_TMRA_LO_RST 8'hD0
`define BBF_TMRA_HI_RST 8'h07
`define BBF_TMRB_LO_RST 8'hD0
`define BBF_TMRB_HI_RST 8'h07

// ============================================================
// Descriptor constants
// ============================================================
`define BBF_CLASS_REV 16'h0110
`define BBF_CFG_UNSPEC 2'h0

// ============================================================
// Timing
// ============================================================
`define BBF_CLK_PERIOD_PS 4000
`define BBF_TICK_PERIOD_MS 10
`define BBF_PS_PER_MS 1000000000
`define BBF_DETACH_TICKS 16'h0001

// ============================================================
// Sequencer states
// ============================================================
`define BBF_ST_STD 3'h0
`define BBF_ST_DET_IN 3'h1
`define BBF_ST_BILL 3'h2
`define BBF_ST_DET_OUT 3'h3
`define BBF_ST_REARM 3'h4

`endif

// *** bbf_failover_seq.v ***
// Purpose: Switches the internal feature-controller device into a Billboard
//          personality on a failure pin and back again on detach timer expiry.
// Assumes: All inputs synchronous to clk_sys; AHB-Lite single word transfers.
// Notes: One 10 ms tick serves both detach timers and the forced detach hold.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "bbf_defs.vh"

// Notes on behaviour
// - Failure input comes from the pin chosen by the 5-bit select field.
// - Default select code picks pin sixty-eight as the failure input.
// - Control bit 0 enables the whole Billboard feature when set.
// - Failure input is active low; low starts the Billboard sequence.
// - On a low pin, first force the internal device to detach.
// - Then reattach with Billboard class revision 1.1 descriptors.
// - Timer A starts when the host assigns the Billboard device an address.
// - Billboard only on modal failure; configured field reports unspecified error.
// - Alternate-mode string request is answered and starts timer B.
// - Whichever timer expires first forces another detach.
// - After that detach, reattach with standard descriptors and functions.
// - Timer A timeout is 16 bits of 10 ms, low and high bytes writable.
// - Default timeout count is 07D0h, two thousand ticks, twenty seconds.
// - Timer B also counts 10 ms units; low byte at its own offset.
// - Billboard descriptors carry the failure message from one-time memory.
// - Timer B high byte sits in its own writable register.
module bbf_failover_seq #(
    parameter NUM_PINS = 17,
    // Divide before multiplying: ten milliseconds in picoseconds does not fit in 32 bits.
    parameter TICK_CYCLES = `BBF_TICK_PERIOD_MS * (`BBF_PS_PER_MS / `BBF_CLK_PERIOD_PS)
) (
    input wire clk_sys,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    input wire [NUM_PINS-1:0] generalIoPin,
    input wire addrAssigned,
    input wire altStringReq,
    output reg devDetach,
    output reg billboardSel,
    output reg altStringAck,
    output reg otpMsgSel,
    output reg [15:0] classRev,
    output reg [1:0] cfgStatus
);

    // ============================================================
    // Register file and bus slave state
    // ============================================================
    reg [7:0] ctrl_q;
    reg [7:0] tmrALo_q;
    reg [7:0] tmrAHi_q;
    reg [7:0] tmrBLo_q;
    reg [7:0] tmrBHi_q;
    reg wrPend_q;
    reg [15:0] wrIdx_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg pinLvl_q;
    reg [31:0] tickCnt_q;
    reg tick_q;
    reg [15:0] tmrA_q;
    reg [15:0] tmrB_q;
    reg runA_q;
    reg runB_q;
    reg [15:0] holdCnt_q;
    reg [7:0] rdByte;
    wire addrPhase;
    wire [15:0] addrIdx;
    wire featureOn;
    wire [4:0] pinSel;
    wire selValid;
    wire pinFail;
    wire expireA;
    wire expireB;
    wire holdDone;
    wire inBill;
    wire [15:0] timeoutA;
    wire [15:0] timeoutB;
    wire [7:0] statusByte;

    assign addrPhase = hsel & hready & htrans[1];
    assign addrIdx = haddr[17:2];
    assign featureOn = ctrl_q[`BBF_CTRL_EN_BIT];
    assign pinSel = ctrl_q[`BBF_CTRL_SEL_MSB:`BBF_CTRL_SEL_LSB];
    assign timeoutA = {tmrAHi_q, tmrALo_q};
    assign timeoutB = {tmrBHi_q, tmrBLo_q};
    assign inBill = (state_q == `BBF_ST_BILL);

    // Reserved and unlisted select codes read as a high pin, so they never trigger.
    assign selValid = (pinSel != `BBF_SEL_RESERVED) && (pinSel <= `BBF_SEL_LAST);
    // Low level means failure; a disabled feature masks the pin out entirely.
    assign pinFail = featureOn & ~pinLvl_q;

    // ============================================================
    // Failure pin selection
    // ============================================================
    // The chosen pin is registered once so the sequencer sees a clean level.
    always @(posedge clk_sys) begin
        if (rst) begin
            pinLvl_q <= 1'b1;
        end else if (selValid && ({27'h0, pinSel} < NUM_PINS)) begin
            pinLvl_q <= generalIoPin[pinSel];
        end else begin
            pinLvl_q <= 1'b1;
        end
    end

    // ============================================================
    // 10 ms tick divider
    // ============================================================
    // A single free-running divider keeps both timers on a common time base.
    always @(posedge clk_sys) begin
        if (rst) begin
            tickCnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (tickCnt_q >= TICK_CYCLES - 1) begin
            tickCnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            tickCnt_q <= tickCnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // ============================================================
    // Detach timers
    // ============================================================
    // A count of zero expires on the first tick, which is the safest reading.
    assign expireA = runA_q & tick_q & ((tmrA_q + 16'h1) >= timeoutA);
    assign expireB = runB_q & tick_q & ((tmrB_q + 16'h1) >= timeoutB);

    // Both timers run only in Billboard state and are cleared on any exit.
    always @(posedge clk_sys) begin
        if (rst || !inBill) begin
            tmrA_q <= 16'h0;
            tmrB_q <= 16'h0;
            runA_q <= 1'b0;
            runB_q <= 1'b0;
        end else begin
            if (addrAssigned && !runA_q) begin
                runA_q <= 1'b1;
            end else if (runA_q && tick_q) begin
                tmrA_q <= tmrA_q + 16'h1;
            end
            if (altStringReq && !runB_q) begin
                runB_q <= 1'b1;
            end else if (runB_q && tick_q) begin
                tmrB_q <= tmrB_q + 16'h1;
            end
        end
    end

    // ============================================================
    // Forced detach hold counter
    // ============================================================
    // The detach is held until the next tick, anywhere from one clock to one whole tick long.
    assign holdDone = tick_q && (holdCnt_q + 16'h1 >= `BBF_DETACH_TICKS);

    always @(posedge clk_sys) begin
        if (rst || (state_q != `BBF_ST_DET_IN && state_q != `BBF_ST_DET_OUT)) begin
            holdCnt_q <= 16'h0;
        end else if (tick_q) begin
            holdCnt_q <= holdCnt_q + 16'h1;
        end
    end

    // ============================================================
    // Personality sequencer
    // ============================================================
    // After the return to standard, a fresh failure needs the pin to go high or the feature to be disabled first,
    // otherwise a held-low pin would bounce the device between personalities.
    always @* begin
        state_d = state_q;
        case (state_q)
            `BBF_ST_STD: begin
                if (pinFail) begin
                    state_d = `BBF_ST_DET_IN;
                end
            end
            `BBF_ST_DET_IN: begin
                if (!featureOn) begin
                    state_d = `BBF_ST_STD;
                end else if (holdDone) begin
                    state_d = `BBF_ST_BILL;
                end
            end
            `BBF_ST_BILL: begin
                if (expireA || expireB || !featureOn) begin
                    state_d = `BBF_ST_DET_OUT;
                end
            end
            `BBF_ST_DET_OUT: begin
                if (holdDone) begin
                    state_d = `BBF_ST_REARM;
                end
            end
            `BBF_ST_REARM: begin
                if (!pinFail) begin
                    state_d = `BBF_ST_STD;
                end
            end
            default: begin
                state_d = `BBF_ST_STD;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_q <= `BBF_ST_STD;
        end else begin
            state_q <= state_d;
        end
    end

    // Detach and select outputs are registered from the next state to avoid glitches.
    always @(posedge clk_sys) begin
        if (rst) begin
            devDetach <= 1'b0;
            billboardSel <= 1'b0;
            otpMsgSel <= 1'b0;
            altStringAck <= 1'b0;
            classRev <= `BBF_CLASS_REV;
            cfgStatus <= `BBF_CFG_UNSPEC;
        end else begin
            devDetach <= (state_d == `BBF_ST_DET_IN) || (state_d == `BBF_ST_DET_OUT);
            billboardSel <= (state_d == `BBF_ST_BILL);
            otpMsgSel <= (state_d == `BBF_ST_BILL);
            altStringAck <= inBill & altStringReq;
            classRev <= `BBF_CLASS_REV;
            cfgStatus <= `BBF_CFG_UNSPEC;
        end
    end

    // ============================================================
    // AHB-Lite slave
    // ============================================================
    // Zero wait states: the address phase is latched and the write lands in the
    // data phase; reads are prepared in the address phase and forwarded from a
    // write in flight to the same register so no stale byte is returned.
    assign statusByte = {1'b0, billboardSel, pinLvl_q, runB_q, runA_q, state_q};

    always @(posedge clk_sys) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrIdx_q <= 16'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wrPend_q <= addrPhase & hwrite;
            wrIdx_q <= addrIdx;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Writes take the low byte lane; reserved control bits stay zero.
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= `BBF_CTRL_RST;
            tmrALo_q <= `BBF_TMRA_LO_RST;
            tmrAHi_q <= `BBF_TMRA_HI_RST;
            tmrBLo_q <= `BBF_TMRB_LO_RST;
            tmrBHi_q <= `BBF_TMRB_HI_RST;
        end else if (wrPend_q) begin
            case (wrIdx_q)
                `BBF_IDX_CTRL: ctrl_q <= hwdata[7:0] & `BBF_CTRL_WMASK;
                `BBF_IDX_TMRA_LO: tmrALo_q <= hwdata[7:0];
                `BBF_IDX_TMRA_HI: tmrAHi_q <= hwdata[7:0];
                `BBF_IDX_TMRB_LO: tmrBLo_q <= hwdata[7:0];
                `BBF_IDX_TMRB_HI: tmrBHi_q <= hwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped indexes and the upper bits read as zero.
    always @* begin
        case (addrIdx)
            `BBF_IDX_CTRL: rdByte = ctrl_q;
            `BBF_IDX_TMRA_LO: rdByte = tmrALo_q;
            `BBF_IDX_TMRA_HI: rdByte = tmrAHi_q;
            `BBF_IDX_TMRB_LO: rdByte = tmrBLo_q;
            `BBF_IDX_TMRB_HI: rdByte = tmrBHi_q;
            `BBF_IDX_STATUS: rdByte = statusByte;
            default: rdByte = 8'h00;
        endcase
        if (wrPend_q && (wrIdx_q == addrIdx) && (addrIdx != `BBF_IDX_STATUS)) begin
            if (addrIdx == `BBF_IDX_CTRL) begin
                rdByte = hwdata[7:0] & `BBF_CTRL_WMASK;
            end else if (rdByte != 8'h00 || addrIdx[15:2] == 14'h104F) begin
                rdByte = hwdata[7:0];
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            hrdata <= 32'h0;
        end else if (addrPhase && !hwrite) begin
            hrdata <= {24'h0, rdByte};
        end
    end

endmodule // bbf_failover_seq

// *** bbf_seq_monitor.sv ***
// Purpose: Port checker for the billboard failover sequencer.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: A forced detach is bounded by one tick plus a small margin.
`timescale 1ns/1ps
// ====================
// Checker
// ====================
module bbf_seq_monitor #(
    parameter NUM_PINS = 17,
    parameter TICK_CYCLES = 20
) (
    input wire clk_sys,
    input wire rst,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire [NUM_PINS-1:0] generalIoPin,
    input wire altStringReq,
    input wire devDetach,
    input wire billboardSel,
    input wire altStringAck,
    input wire otpMsgSel,
    input wire [15:0] classRev,
    input wire [1:0] cfgStatus
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    int detachRun;
    // Length of the current detach; a stuck detach would hide the device for good.
    always @(posedge clk_sys) begin
        if (rst || !devDetach) begin
            detachRun <= 0;
        end else begin
            detachRun <= detachRun + 1;
        end
    end
    // Steps of leaving and of being asked for the mode string.
    sequence seqLeaveBill; billboardSel ##1 !billboardSel; endsequence
    sequence seqReqInBill; altStringReq && billboardSel; endsequence
    a_bus_ready: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_otp_follows: assert property (otpMsgSel == billboardSel)
        else $error("message select differs from billboard select");
    a_desc_consts: assert property (classRev == 16'h0110 && cfgStatus == 2'h0)
        else $error("descriptor constants wrong");
    a_enter_detached: assert property ($rose(billboardSel) |-> $past(devDetach) && !devDetach)
        else $error("billboard entered without detach");
    a_leave_detached: assert property (seqLeaveBill |-> devDetach)
        else $error("billboard left without detach");
    a_detach_cause: assert property ($rose(devDetach) && !$past(billboardSel) |-> !(&$past(generalIoPin)))
        else $error("detach with no low pin");
    a_ack_follows: assert property (seqReqInBill |=> altStringAck)
        else $error("string request not acknowledged");
    a_ack_cause: assert property (altStringAck |-> $past(altStringReq))
        else $error("acknowledge without request");
    a_detach_short: assert property (detachRun <= TICK_CYCLES + 2)
        else $error("detach held too long");
endmodule // bbf_seq_monitor
bind bbf_failover_seq bbf_seq_monitor #(.NUM_PINS(NUM_PINS), .TICK_CYCLES(TICK_CYCLES)) u_mon (
    .clk_sys(clk_sys), .rst(rst), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .generalIoPin(generalIoPin), .altStringReq(altStringReq), .devDetach(devDetach),
    .billboardSel(billboardSel), .altStringAck(altStringAck), .otpMsgSel(otpMsgSel),
    .classRev(classRev), .cfgStatus(cfgStatus));

// *** bbf_pd_host.sv ***
// Purpose: Model of the PD controller and USB host beside the sequencer.
// Assumes: Unused pins idle high through their pull-ups.
// Notes: Commands are levels; each rising edge makes one host event.
`timescale 1ns/1ps
// ====================
// Far-side model
// ====================
module bbf_pd_host (
    input wire clk_sys,
    input wire rst,
    input wire failOn,
    input wire [4:0] failCode,
    input wire addrCmd,
    input wire strCmd,
    output reg [16:0] generalIoPin,
    output reg addrAssigned,
    output reg altStringReq
);
    reg addrCmd_q;
    reg strCmd_q;
    // Only the chosen pin is pulled low on a failure, so a wrong select shows up.
    always @(posedge clk_sys) begin
        if (failOn) begin
            generalIoPin <= ~(17'h00001 << failCode);
        end else begin
            generalIoPin <= 17'h1FFFF;
        end
        addrCmd_q <= addrCmd & !rst;
        strCmd_q <= strCmd & !rst;
        addrAssigned <= addrCmd & !addrCmd_q;
        altStringReq <= strCmd & !strCmd_q;
    end
endmodule // bbf_pd_host

// *** test_billboard_failover_sequencer.sv ***
// Purpose: Self-checking bench for the billboard failover sequencer.
// Assumes: The 10 ms tick is shortened to TK clocks.
// Notes: A row table covers the writable registers and one unmapped index; sequences follow by hand.
`timescale 1ns/1ps
`include "bbf_defs.vh"
// ====================
// Compare and bounded wait
// ====================
`define CHK(nm, exp, got) begin \
    numChecks++; \
    if ((got) !== (exp)) begin \
        $display("ERROR %s expected %h seen %h", nm, exp, got); \
        nErrors++; \
    end \
end
`define WAITF(nm, cond, lim) begin \
    for (wt = 0; wt < (lim) && !(cond); wt++) @(posedge clk_sys); \
    `CHK(nm, 1'b1, (cond)) \
    if (!(cond)) test_done; \
end
module test_billboard_failover_sequencer;
    localparam int TK = 20;
    logic clk_sys, rst, hsel, hwrite, hreadyout, hresp, devDetach, billboardSel;
    logic addrAssigned, altStringReq, altStringAck, otpMsgSel, failOn, addrCmd, strCmd;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, cfgStatus;
    logic [2:0] hsize;
    logic [4:0] failCode;
    logic [15:0] classRev;
    logic [16:0] generalIoPin;
    int nErrors = 0;
    int numChecks = 0;
    int wt, c;
    // Rows: register index, reset value, value written, value read back.
    logic [15:0] rIdx [6] = '{`BBF_IDX_CTRL, `BBF_IDX_TMRA_LO, `BBF_IDX_TMRA_HI,
        `BBF_IDX_TMRB_LO, `BBF_IDX_TMRB_HI, 16'h0100};
    logic [7:0] rRst [6] = '{8'h14, 8'hD0, 8'h07, 8'hD0, 8'h07, 8'h00};
    logic [7:0] rWr [6] = '{8'hFF, 8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h5A};
    logic [7:0] rExp [6] = '{8'h3F, 8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h00};
    bbf_failover_seq #(.NUM_PINS(17), .TICK_CYCLES(TK)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .generalIoPin(generalIoPin),
        .addrAssigned(addrAssigned), .altStringReq(altStringReq), .devDetach(devDetach),
        .billboardSel(billboardSel), .altStringAck(altStringAck), .otpMsgSel(otpMsgSel),
        .classRev(classRev), .cfgStatus(cfgStatus));
    bbf_pd_host u_host (.clk_sys(clk_sys), .rst(rst), .failOn(failOn), .failCode(failCode),
        .addrCmd(addrCmd), .strCmd(strCmd), .generalIoPin(generalIoPin),
        .addrAssigned(addrAssigned), .altStringReq(altStringReq));
    // Free-running 250 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // One single-word transfer; each phase is held until hready is seen high.
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk_sys);
        `WAITF("addr ready", hreadyout, 50)
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        `WAITF("data ready", hreadyout, 50)
        rd = hrdata;
        `CHK("resp okay", 1'b0, hresp)
    endtask
    // The far side reports a failure on one pin, or lets all pins go high again.
    task fail(input logic [4:0] code);
        @(posedge clk_sys);
        failCode <= code;
        failOn <= 1'b1;
    endtask
    task idle;
        @(posedge clk_sys);
        failOn <= 1'b0;
        repeat (3 * TK) @(posedge clk_sys);
    endtask
    task test_done;
        $display("Checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence: registers, disabled feature, select codes 0 to 16, both timers.
    initial begin
        {rst, hsel, hwrite, failOn, addrCmd, strCmd} = 6'h20;
        {haddr, hwdata, htrans, hsize, failCode} = {64'h0, 2'h0, 3'h2, 5'h0A};
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        for (c = 0; c < 6; c++) begin
            xfer(1'b0, rIdx[c], 8'h00);
            `CHK("reg reset", {24'h000000, rRst[c]}, rd)
            xfer(1'b1, rIdx[c], rWr[c]);
            xfer(1'b0, rIdx[c], 8'h00);
            `CHK("reg access", {24'h000000, rExp[c]}, rd)
        end
        xfer(1'b1, `BBF_IDX_CTRL, 8'h14);
        fail(5'h0A);
        repeat (3 * TK) @(posedge clk_sys);
        `CHK("disabled", 1'b0, devDetach | billboardSel)
        idle;
        for (c = 0; c < 17; c++) begin
            xfer(1'b1, `BBF_IDX_CTRL, {2'h0, c[4:0], 1'b1});
            fail(c[4:0]);
            if (c == 9) begin
                repeat (3 * TK) @(posedge clk_sys);
                `CHK("reserved code", 1'b0, devDetach)
            end else begin
                `WAITF("detach in", devDetach, 2 * TK)
                `WAITF("bill in", billboardSel, 2 * TK)
                `CHK("otp msg", 1'b1, otpMsgSel)
            end
            xfer(1'b1, `BBF_IDX_CTRL, 8'h14);
            `WAITF("bill out", !billboardSel, 2 * TK)
            idle;
        end
        xfer(1'b1, `BBF_IDX_TMRA_LO, 8'h03);
        xfer(1'b1, `BBF_IDX_TMRA_HI, 8'h00);
        xfer(1'b1, `BBF_IDX_TMRB_HI, 8'h01);
        xfer(1'b1, `BBF_IDX_CTRL, 8'h15);
        fail(5'h0A);
        `WAITF("bill a", billboardSel, 4 * TK)
        addrCmd <= 1'b1;
        `WAITF("timer a", !billboardSel, 5 * TK)
        `CHK("timer a span", 1'b1, wt > 2 * TK && wt <= 3 * TK + 8)
        `CHK("exit detach", 1'b1, devDetach)
        addrCmd <= 1'b0;
        idle;
        `CHK("standard", 1'b0, billboardSel | devDetach)
        xfer(1'b1, `BBF_IDX_TMRA_HI, 8'h01);
        xfer(1'b1, `BBF_IDX_TMRB_LO, 8'h02);
        xfer(1'b1, `BBF_IDX_TMRB_HI, 8'h00);
        fail(5'h0A);
        `WAITF("bill b", billboardSel, 4 * TK)
        `CHK("class rev", `BBF_CLASS_REV, classRev)
        `CHK("cfg status", `BBF_CFG_UNSPEC, cfgStatus)
        strCmd <= 1'b1;
        @(posedge clk_sys);
        `WAITF("alt ack", altStringAck, 4)
        `WAITF("timer b", !billboardSel, 4 * TK)
        `CHK("timer b span", 1'b1, wt > TK - 4 && wt <= 2 * TK + 8)
        strCmd <= 1'b0;
        idle;
        // Reset in the middle of a Billboard session: outputs drop and registers reload.
        fail(5'h0A);
        `WAITF("bill r", billboardSel, 4 * TK)
        rst <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        `CHK("reset outs", 2'h0, {billboardSel, devDetach})
        xfer(1'b0, `BBF_IDX_CTRL, 8'h00);
        `CHK("reset ctrl", {24'h000000, `BBF_CTRL_RST}, rd)
        xfer(1'b0, `BBF_IDX_TMRA_LO, 8'h00);
        `CHK("reset tmr a", {24'h000000, `BBF_TMRA_LO_RST}, rd)
        repeat (3 * TK) @(posedge clk_sys);
        `CHK("reset idle", 1'b0, devDetach)
        idle;
        test_done;
    end
endmodule // test_billboard_failover_sequencer
